//--- core/stp_pkg.sv
package stp_pkg;

	// ------------------------------------------------------------
	// radio states seen by this block
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		STP_ST_OTHER        = 4'h0,
		STP_ST_SYNTH_READY  = 4'h1,
		STP_ST_ARET_READY   = 4'h2,
		STP_ST_AACK_RX      = 4'h3,
		STP_ST_IDLE         = 4'h4,
		STP_ST_SLEEP        = 4'h5,
		STP_ST_LISTEN       = 4'h6,
		STP_ST_LISTEN_NOCLK = 4'h7,
		STP_ST_AACK_LISTEN  = 4'h8,
		STP_ST_AACK_NOCLK   = 4'h9
	} stp_state_e;

	// ------------------------------------------------------------
	// constants
	// ------------------------------------------------------------
	localparam logic [5:0] STP_CLK_DELAY    = 6'h23;
	localparam logic [2:0] STP_RATE_FAST_LO = 3'h6;
	localparam logic [5:0] STP_CNT_ZERO     = 6'h00;
	localparam logic [5:0] STP_CNT_ONE      = 6'h01;

	// requests from this block to the radio core
	typedef struct packed {
		logic tx_start;
		logic aret_start;
		logic ack_start;
	} stp_cmd_s;

endpackage

//--- core/stp_sleep_tx_pin_control.sv
`timescale 1ns/1ps
`default_nettype none

module stp_sleep_tx_pin_control
	import stp_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       sleep_tx_pin_in,
	input  wire stp_state_e radio_state_in,
	input  wire logic       slotted_in,
	input  wire logic       rx_start_in,
	input  wire logic [2:0] clock_output_rate_select_in,
	input  wire logic       host_clock_tick_in,
	output stp_state_e      state_out,
	output logic            state_override_out,
	output stp_cmd_s        cmd_out,
	output logic            rx_busy_out,
	output logic            host_clock_enable_out
);

	// ------------------------------------------------------------
	// pin synchroniser and edges
	// ------------------------------------------------------------
	logic sync1_reg;
	logic sync2_reg;
	logic pin_prev_reg;
	logic rise;
	logic fall;

	// only the second and third flops are read; the first may settle late
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_reg    <= 1'b0;
			sync2_reg    <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			sync1_reg    <= sleep_tx_pin_in;
			sync2_reg    <= sync1_reg;
			pin_prev_reg <= sync2_reg;
		end
	end

	assign rise = sync2_reg & ~pin_prev_reg;
	assign fall = ~sync2_reg & pin_prev_reg;

	// ------------------------------------------------------------
	// pin-owned state
	// ------------------------------------------------------------
	stp_state_e state_reg;
	stp_state_e state_next;
	logic       own_reg;
	logic       own_next;
	logic       fast_rate;

	assign fast_rate = clock_output_rate_select_in >= STP_RATE_FAST_LO;

	always_comb begin
		state_next = state_reg;
		own_next   = own_reg;
		if (!own_reg) begin
			// nothing owned by the pin: follow the radio core
			state_next = radio_state_in;
			if (rise) begin
				case (radio_state_in)
					STP_ST_IDLE: begin
						state_next = STP_ST_SLEEP;
						own_next   = 1'b1;
					end
					STP_ST_LISTEN: begin
						state_next = STP_ST_LISTEN_NOCLK;
						own_next   = 1'b1;
					end
					STP_ST_AACK_LISTEN: begin
						state_next = STP_ST_AACK_NOCLK;
						own_next   = 1'b1;
					end
					default: own_next = 1'b0;
				endcase
			end
		end else begin
			case (state_reg)
				STP_ST_SLEEP: begin
					// wake-up follows the pin level, no edge needed
					if (!sync2_reg) begin
						state_next = STP_ST_IDLE;
						own_next   = 1'b0;
					end
				end
				STP_ST_LISTEN_NOCLK: begin
					if (fall) begin
						state_next = STP_ST_LISTEN;
						own_next   = 1'b0;
					end
				end
				STP_ST_AACK_NOCLK: begin
					if (fall) begin
						state_next = STP_ST_AACK_LISTEN;
						own_next   = 1'b0;
					end
				end
				default: begin
					state_next = radio_state_in;
					own_next   = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= STP_ST_OTHER;
			own_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			own_reg   <= own_next;
		end
	end

	assign state_out          = state_reg;
	assign state_override_out = own_reg;

	// ------------------------------------------------------------
	// transmit triggers
	// ------------------------------------------------------------
	logic rise_free;

	// an edge is ignored while the pin owns the state
	assign rise_free = rise && !own_reg;

	// one-cycle requests towards the radio core
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_out <= '0;
		end else begin
			cmd_out.tx_start   <= rise_free
				&& radio_state_in == STP_ST_SYNTH_READY;
			cmd_out.aret_start <= rise_free
				&& radio_state_in == STP_ST_ARET_READY;
			cmd_out.ack_start  <= rise_free && slotted_in
				&& radio_state_in == STP_ST_AACK_RX;
		end
	end

	// ------------------------------------------------------------
	// reception start marker
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_busy_out <= 1'b0;
		end else begin
			// pulse marks entry into busy receive
			rx_busy_out <= rx_start_in;
		end
	end

	// ------------------------------------------------------------
	// host clock output gating
	// ------------------------------------------------------------
	logic [5:0] cnt_reg;
	logic       entering_off;
	logic       in_noclk;
	logic       rx_restart;
	logic       delay_last;

	assign entering_off = own_next && !own_reg;
	assign in_noclk     = state_reg == STP_ST_LISTEN_NOCLK
		|| state_reg == STP_ST_AACK_NOCLK;
	assign rx_restart   = in_noclk && rx_start_in;
	// the tick that takes the counter from one to zero ends the grace period
	assign delay_last   = cnt_reg == STP_CNT_ONE && host_clock_tick_in;

	// ------------------------------------------------------------
	// grace period counter, in host clock output cycles
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= STP_CNT_ZERO;
		end else if (!own_next || rx_restart) begin
			cnt_reg <= STP_CNT_ZERO;
		end else if (entering_off) begin
			// the fast rates never clock the host, so they get no grace period
			cnt_reg <= fast_rate ? STP_CNT_ZERO : STP_CLK_DELAY;
		end else if (cnt_reg != STP_CNT_ZERO && host_clock_tick_in) begin
			cnt_reg <= cnt_reg - STP_CNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// clock output gate
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			host_clock_enable_out <= 1'b1;
		end else if (!own_next) begin
			host_clock_enable_out <= 1'b1;
		end else if (entering_off) begin
			// a clocked host keeps its clock until the grace period ends
			host_clock_enable_out <= !fast_rate;
		end else if (rx_restart) begin
			host_clock_enable_out <= 1'b1;
		end else if (delay_last) begin
			host_clock_enable_out <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- dv/stp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module stp_chk
	import stp_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       sleep_tx_pin_in,
	input wire stp_state_e radio_state_in,
	input wire logic       slotted_in,
	input wire logic       rx_start_in,
	input wire logic [2:0] clock_output_rate_select_in,
	input wire logic       host_clock_tick_in,
	input wire stp_state_e state_out,
	input wire logic       state_override_out,
	input wire stp_cmd_s   cmd_out,
	input wire logic       rx_busy_out,
	input wire logic       host_clock_enable_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic n;
	logic [5:0] n_reg;
	assign n = clock_output_rate_select_in[2:1] == 2'h3;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in | !state_override_out)
			n_reg <= 6'h00;
		else
			n_reg <= n_reg + {5'h00, host_clock_tick_in};
	end
	property p_tx; cmd_out.tx_start |-> $past(radio_state_in) == STP_ST_SYNTH_READY; endproperty
	a_tx: assert property (p_tx) else $error("bad tx start");
	property p_ar; cmd_out.aret_start |-> $past(radio_state_in) == STP_ST_ARET_READY; endproperty
	a_ar: assert property (p_ar) else $error("bad retry start");
	property p_ack;
		cmd_out.ack_start |-> $past(slotted_in) && $past(radio_state_in) == STP_ST_AACK_RX;
	endproperty
	a_ack: assert property (p_ack) else $error("bad ack start");
	property p_one; cmd_out != 3'h0 |=> cmd_out == 3'h0; endproperty
	a_one: assert property (p_one) else $error("cmd too long");
	property p_fast; $rose(state_override_out) && n |-> !host_clock_enable_out; endproperty
	a_fast: assert property (p_fast) else $error("fast clock kept");
	property p_dly; $fell(host_clock_enable_out) && !n |-> n_reg == 6'h23; endproperty
	a_dly: assert property (p_dly) else $error("bad stop delay");
	property p_wake;
		state_out == STP_ST_SLEEP && !sleep_tx_pin_in |-> ##[1:3] !state_override_out;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from sleep");
	property p_back; $fell(state_override_out) |-> host_clock_enable_out; endproperty
	a_back: assert property (p_back) else $error("clock not back");
	property p_rx; rx_start_in |=> rx_busy_out; endproperty
	a_rx: assert property (p_rx) else $error("no busy");
	property p_rxc;
		state_override_out && state_out != STP_ST_SLEEP && rx_start_in
			|=> ##[0:1] host_clock_enable_out;
	endproperty
	a_rxc: assert property (p_rxc) else $error("no restart");
	c_ovr: cover property ($rose(state_override_out));
	c_off: cover property ($fell(host_clock_enable_out));
	c_ack: cover property (cmd_out.ack_start);
endmodule
bind stp_sleep_tx_pin_control stp_chk i_chk (.*);
`default_nettype wire

//--- dv/stp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module stp_host_model (
	input  wire logic clk_in,
	input  wire logic pin_req_in,
	output logic      pin_out = 1'b0,
	output logic      tick_out = 1'b0
);
	logic [1:0] div_reg = 2'h0;
	// host drives the pin only on request; tick_out pulses once every four clocks
	always @(negedge clk_in) begin
		pin_out <= pin_req_in;
		div_reg <= div_reg + 2'h1;
		tick_out <= (div_reg == 2'h3);
	end
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import stp_pkg::*;
	logic clk_in = 1'b0, rst_in = 1'b1, req = 1'b0, slotted_in = 1'b0, rx_start_in = 1'b0;
	logic sleep_tx_pin_in, host_clock_tick_in, state_override_out, rx_busy_out;
	logic host_clock_enable_out;
	logic [2:0] clock_output_rate_select_in = 3'h0;
	logic [5:0] n = 6'h00;
	stp_state_e radio_state_in = STP_ST_OTHER, state_out;
	stp_cmd_s cmd_out;
	int err_count = 0, checks = 0;
	stp_sleep_tx_pin_control i_dut (
		.clk_in                      (clk_in),
		.rst_in                      (rst_in),
		.sleep_tx_pin_in             (sleep_tx_pin_in),
		.radio_state_in              (radio_state_in),
		.slotted_in                  (slotted_in),
		.rx_start_in                 (rx_start_in),
		.clock_output_rate_select_in (clock_output_rate_select_in),
		.host_clock_tick_in          (host_clock_tick_in),
		.state_out                   (state_out),
		.state_override_out          (state_override_out),
		.cmd_out                     (cmd_out),
		.rx_busy_out                 (rx_busy_out),
		.host_clock_enable_out       (host_clock_enable_out)
	);
	stp_host_model i_host (.clk_in(clk_in), .pin_req_in(req), .pin_out(sleep_tx_pin_in),
		.tick_out(host_clock_tick_in));
	initial forever #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) n <= state_override_out ? n + 6'(host_clock_tick_in) : 6'h00;
	task automatic chk(input logic [5:0] s, input logic [5:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_in);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic t_cmd(input stp_state_e s, input logic sl, input logic [2:0] e);
		logic [2:0] seen;
		seen = 3'h0;
		radio_state_in = s;
		slotted_in = sl;
		req = 1'b1;
		repeat (8) begin
			@(negedge clk_in);
			seen = seen | cmd_out;
		end
		chk(6'(seen), 6'(e));
		req = 1'b0;
		cyc(6);
		$display("cmd test done");
	endtask
	task automatic t_off(input stp_state_e s, input logic [2:0] r, input stp_state_e e);
		radio_state_in = s;
		clock_output_rate_select_in = r;
		req = 1'b1;
		cyc(6);
		chk(6'(state_out), 6'(e));
		if (r[2:1] == 2'h3) chk(6'(host_clock_enable_out), 6'h00);
		else begin
			for (int k = 0; k < 400 && host_clock_enable_out === 1'b1; k++) cyc(1);
			chk(n, 6'h23);
		end
		chk(6'(state_override_out), 6'h01);
		req = 1'b0;
		cyc(6);
		chk(6'(state_out), 6'(s));
		chk(6'(host_clock_enable_out), 6'h01);
		$display("clock-off test done");
	endtask
	task automatic t_rx;
		radio_state_in = STP_ST_LISTEN;
		clock_output_rate_select_in = 3'h6;
		req = 1'b1;
		cyc(6);
		chk(6'(host_clock_enable_out), 6'h00);
		rx_start_in = 1'b1;
		cyc(1);
		rx_start_in = 1'b0;
		chk(6'(rx_busy_out), 6'h01);
		cyc(1);
		chk(6'(host_clock_enable_out), 6'h01);
		chk(6'(state_out), 6'(STP_ST_LISTEN_NOCLK));
		req = 1'b0;
		cyc(6);
		chk(6'(state_out), 6'(STP_ST_LISTEN));
		$display("receive test done");
	endtask
	initial begin
		cyc(6);
		rst_in = 1'b0;
		t_cmd(STP_ST_SYNTH_READY, 1'b0, 3'h4);
		t_cmd(STP_ST_ARET_READY, 1'b0, 3'h2);
		t_cmd(STP_ST_AACK_RX, 1'b1, 3'h1);
		t_cmd(STP_ST_AACK_RX, 1'b0, 3'h0);
		t_cmd(STP_ST_OTHER, 1'b0, 3'h0);
		t_off(STP_ST_IDLE, 3'h0, STP_ST_SLEEP);
		t_off(STP_ST_IDLE, 3'h7, STP_ST_SLEEP);
		t_off(STP_ST_LISTEN, 3'h1, STP_ST_LISTEN_NOCLK);
		t_off(STP_ST_LISTEN, 3'h6, STP_ST_LISTEN_NOCLK);
		t_off(STP_ST_AACK_LISTEN, 3'h0, STP_ST_AACK_NOCLK);
		t_off(STP_ST_AACK_LISTEN, 3'h7, STP_ST_AACK_NOCLK);
		t_rx;
		wrap_up;
	end
	initial begin
		#100us;
		err_count++;
		wrap_up;
	end
endmodule
`default_nettype wire
